/* File: core/sts_map.svh */
// Purpose: offsets, field positions, encodings and reset values
// Assumes: included by bare name from the unit
// Notes: byte offsets are on the APB, one aligned 32-bit word each
`ifndef STS_MAP_SVH
`define STS_MAP_SVH
// instruction fields
`define STS_F_OP 31:30
`define STS_F_RD 29:25
`define STS_F_OP3 24:19
`define STS_F_RS1 18:14
`define STS_F_I 13
`define STS_F_ASI 12:5
`define STS_F_SIMM 12:0
`define STS_SIMM_SIGN 12
// opcode values
`define STS_OP_MEM 2'h3
`define STS_OP3_ALT_DF 6'h37
`define STS_OP3_TWIN 6'h07
`define STS_OP3_TWIN_ALT 6'h17
// short store space identifiers
`define STS_ASI_BYTE_P 8'hD0
`define STS_ASI_BYTE_S 8'hD1
`define STS_ASI_BYTE_PL 8'hD8
`define STS_ASI_BYTE_SL 8'hD9
`define STS_ASI_HALF_P 8'hD2
`define STS_ASI_HALF_S 8'hD3
`define STS_ASI_HALF_PL 8'hDA
`define STS_ASI_HALF_SL 8'hDB
// space identifier bits and the restricted range
`define STS_B_ASI_HALF 1
`define STS_B_ASI_LE 3
`define STS_B_ASI_UNPRIV 7
`define STS_ASI_RSV_LO 8'h30
`define STS_ASI_RSV_HI 8'h7F
// register offsets
`define STS_R_CTRL 12'h000
`define STS_R_ASI 12'h004
`define STS_R_STAT 12'h008
`define STS_R_CNT 12'h00C
// control bits
`define STS_B_FEF 0
`define STS_B_PEF 1
`define STS_B_FPU 2
`define STS_B_PRIV 3
`define STS_B_TWIN_HW 4
`define STS_CTRL_W 5
`define STS_CTRL_RST 5'h14
// space register fields
`define STS_F_CUR_ASI 7:0
`define STS_F_IMP_ASI 15:8
`define STS_ASI_RST 8'h80
// status fields
`define STS_F_LAST 2:0
`define STS_B_STICKY 8
// lane masks
`define STS_MASK_BYTE 8'h80
`define STS_MASK_HALF 8'hC0
`define STS_MASK_ALL 8'hFF
`endif

/* File: core/sts_pkg.sv */
// Purpose: types shared by the store unit and its users
// Assumes: map header defines the numbers
// Notes: nothing here holds a bare offset or code
`default_nettype none
package sts_pkg;
   // exception codes, none means a memory write goes out
   typedef enum logic [2:0] {
      STS_TRAP_NONE,
      STS_TRAP_ILLEGAL,
      STS_TRAP_FLOAT_DISABLED_FAULT,
      STS_TRAP_PRIV_ACTION,
      STS_TRAP_MISALIGNED,
      STS_TRAP_DATA_ACCESS,
      STS_TRAP_UNIMPL_TWIN
   } sts_trap_t;
   // request from the issue stage
   typedef struct packed {
      logic [31:0] insn;
      logic [63:0] rs1_val;
      logic [63:0] rs2_val;
      logic [63:0] rd_even_val;
      logic [63:0] rd_odd_val;
      logic [63:0] fp_val;
   } sts_issue_t;
   // result toward the memory pipeline
   typedef struct packed {
      sts_trap_t trap;
      logic [63:0] addr;
      logic [7:0] asi;
      logic [63:0] data;
      logic [7:0] mask;
   } sts_result_t;
endpackage
`default_nettype wire

/* File: core/sts_store_unit.sv */
// Purpose: decode, check and format short fp and twin-word stores
// Assumes: issue side and memory side run on pclk; APB register slave
// Notes: one result per accepted instruction, one cycle after issue
//
// The implementer's own choices: the register offsets and register access over APB.
`default_nettype none
`include "sts_map.svh"
// Notes on behaviour
// - D0/D1 byte stores, D8/D9 little forms
// - D2/D3 halfword stores, DA/DB little forms
// - short store found only by space id
// - only low 8 or 16 bits written
// - little ids swap bytes, else big-endian
// - short store raises data access exception
// - float_disabled_fault if any enable low
// - byte short store needs no alignment
// - odd halfword short store is misaligned
// - even reg low word, then odd reg
// - odd rd or nonzero bits 12:5 illegal
// - address is rs1 plus rs2 or immediate
// - plain twin store uses implicit space
// - both twin words written as one beat
// - twin store needs eight-byte alignment
// - little twin swaps each word separately
// - twin store absent raises unimplemented trap
// - alt twin space from field or register
// - space bit 7 low means privileged
// - user mode privileged space raises trap
// - privileged mode, 30..7F raises trap
// - alt twin with odd rd illegal
// - alt twin needs eight-byte alignment
module sts_store_unit #(
   // apb byte address width
   parameter int ADDR_W = 12,
   // 0: short fp stores trap so software can emulate them
   parameter bit SHORT_FP_IN_HW = 1'b0
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb register slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // issue side handshake
   input wire logic issue_valid,
   output logic issue_ready,
   input wire sts_pkg::sts_issue_t issue,
   // memory side result
   output logic res_valid,
   input wire logic res_ready,
   output sts_pkg::sts_result_t res,
   output logic res_hit
);

   // swap the four bytes of a word
   // used for every little-endian word
   function automatic logic [31:0] swap32(input logic [31:0] w);
      swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   // register state
   logic [`STS_CTRL_W-1:0] ctrl; // enables, mode, twin present
   logic [`STS_CTRL_W-1:0] next_ctrl;
   logic [7:0] cur_asi; // current space id register
   logic [7:0] next_cur_asi;
   logic [7:0] imp_asi; // implicit space id
   logic [7:0] next_imp_asi;
   logic [2:0] last_code; // code of last result
   logic [2:0] next_last_code;
   logic sticky; // a trap was reported
   logic next_sticky;
   logic [31:0] cnt; // memory writes handed on
   logic [31:0] next_cnt;
   // apb read answer
   logic [31:0] next_prdata;
   logic next_pslverr;

   // result state
   logic next_res_valid;
   sts_pkg::sts_result_t next_res;
   logic next_res_hit;

   // decode wires
   // instruction fields
   logic [1:0] f_op; // format
   logic [5:0] f_op3; // opcode within format
   logic [4:0] f_rd; // register pair
   logic f_i; // immediate select
   logic [7:0] f_asi; // space id field
   // address and space
   logic [63:0] simm; // sign-extended immediate
   logic [63:0] ea; // effective address
   logic [7:0] asi_sel; // space id in use
   // store class
   logic is_short; // short fp store
   logic is_twin; // plain twin store
   logic is_twin_alt; // alt-space twin store
   logic short_id; // id is one of the eight
   logic half; // halfword form
   // data formatting
   logic little; // little-endian order
   logic [5:0] sh; // lane shift in bits
   logic [15:0] half_data; // halfword in memory order
   logic [31:0] w_even; // first twin word
   logic [31:0] w_odd; // second twin word
   // enables and handshakes
   logic privileged; // privileged mode
   logic fp_on; // both enables and unit present
   logic wr_acc; // register write this edge
   logic take; // instruction accepted
   logic drain; // result handed on
   // trap chosen for this instruction
   sts_pkg::sts_trap_t trap;

   // handshakes are combinational
   // no wait states, every access phase ends at once
   assign pready = 1'b1;
   // a new instruction fits once the old result leaves
   assign issue_ready = !res_valid || res_ready;
   assign take = issue_valid && issue_ready;
   assign drain = res_valid && res_ready;
   // only a full access phase writes a register
   assign wr_acc = psel && penable && pwrite;

   // field extraction and effective address
   always_comb begin
      // format, register, opcode and select fields
      f_op = issue.insn[`STS_F_OP];
      f_op3 = issue.insn[`STS_F_OP3];
      f_rd = issue.insn[`STS_F_RD];
      f_i = issue.insn[`STS_F_I];
      f_asi = issue.insn[`STS_F_ASI];
      // sign extend the 13-bit immediate
      simm = {{51{issue.insn[`STS_SIMM_SIGN]}}, issue.insn[`STS_F_SIMM]};
      ea = issue.rs1_val + (f_i ? simm : issue.rs2_val);
      // field when i is clear, register when i is set
      asi_sel = f_i ? cur_asi : f_asi;
   end

   // instruction classification
   always_comb begin
      // eight short store ids, byte and halfword forms
      short_id = (asi_sel == `STS_ASI_BYTE_P) || (asi_sel == `STS_ASI_BYTE_S)
         || (asi_sel == `STS_ASI_BYTE_PL) || (asi_sel == `STS_ASI_BYTE_SL)
         || (asi_sel == `STS_ASI_HALF_P) || (asi_sel == `STS_ASI_HALF_S)
         || (asi_sel == `STS_ASI_HALF_PL) || (asi_sel == `STS_ASI_HALF_SL);
      // shared opcode, the space id alone picks the short store
      is_short = (f_op == `STS_OP_MEM) && (f_op3 == `STS_OP3_ALT_DF) && short_id;
      // all three forms share the memory format
      is_twin = (f_op == `STS_OP_MEM) && (f_op3 == `STS_OP3_TWIN);
      is_twin_alt = (f_op == `STS_OP_MEM) && (f_op3 == `STS_OP3_TWIN_ALT);
      // id bit 1 picks halfword over byte
      half = asi_sel[`STS_B_ASI_HALF];
      // plain twin takes its order from the implicit id
      if (is_twin) begin
         little = imp_asi[`STS_B_ASI_LE];
      end else begin
         little = asi_sel[`STS_B_ASI_LE];
      end
      // mode and fp enables from the control register
      privileged = ctrl[`STS_B_PRIV];
      fp_on = ctrl[`STS_B_FEF] && ctrl[`STS_B_PEF] && ctrl[`STS_B_FPU];
   end

   // exception checks in priority order
   always_comb begin
      // default: no trap, the write goes out
      trap = sts_pkg::STS_TRAP_NONE;
      if (is_short) begin
         // short store: enables, then alignment, then emulation
         if (!fp_on) begin
            trap = sts_pkg::STS_TRAP_FLOAT_DISABLED_FAULT;
         end else if (half && ea[0]) begin
            // halfword at an odd address
            trap = sts_pkg::STS_TRAP_MISALIGNED;
         end else if (!SHORT_FP_IN_HW) begin
            // no hardware path, software emulates the store
            trap = sts_pkg::STS_TRAP_DATA_ACCESS;
         end
         // byte form has no alignment
      end else if (is_twin) begin
         // plain twin: presence, register pair and field, alignment
         if (!ctrl[`STS_B_TWIN_HW]) begin
            trap = sts_pkg::STS_TRAP_UNIMPL_TWIN;
         end else if (f_rd[0] || (!f_i && (f_asi != 8'h00))) begin
            // odd pair or stray bits in the unused field
            trap = sts_pkg::STS_TRAP_ILLEGAL;
         end else if (ea[2:0] != 3'h0) begin
            // both words must share one doubleword
            trap = sts_pkg::STS_TRAP_MISALIGNED;
         end
      end else if (is_twin_alt) begin
         // alt twin: presence, register pair, privilege, alignment
         if (!ctrl[`STS_B_TWIN_HW]) begin
            trap = sts_pkg::STS_TRAP_UNIMPL_TWIN;
         end else if (f_rd[0]) begin
            // odd register pair
            trap = sts_pkg::STS_TRAP_ILLEGAL;
         end else if (!privileged && !asi_sel[`STS_B_ASI_UNPRIV]) begin
            // user code may not reach a restricted space
            trap = sts_pkg::STS_TRAP_PRIV_ACTION;
         end else if (privileged && (asi_sel >= `STS_ASI_RSV_LO)
               && (asi_sel <= `STS_ASI_RSV_HI)) begin
            // range closed even to privileged code
            trap = sts_pkg::STS_TRAP_PRIV_ACTION;
         end else if (ea[2:0] != 3'h0) begin
            // doubleword alignment as for the plain form
            trap = sts_pkg::STS_TRAP_MISALIGNED;
         end
      end
      // any other instruction passes with no trap
   end

   // data formatting toward memory
   always_comb begin
      // halfword keeps the low 16 bits, swapped for little ids
      half_data = little ? {issue.fp_val[7:0], issue.fp_val[15:8]}
         : issue.fp_val[15:0];
      // each twin word swapped on its own for little ids
      w_even = little ? swap32(issue.rd_even_val[31:0])
         : issue.rd_even_val[31:0];
      w_odd = little ? swap32(issue.rd_odd_val[31:0])
         : issue.rd_odd_val[31:0];
      // defaults: no shift, hold the result while it waits
      sh = 6'h00;
      next_res = res;
      next_res_hit = res_hit;
      next_res_valid = res_valid && !res_ready;
      if (take) begin
         // a new instruction replaces the result
         next_res_valid = 1'b1;
         // other instructions leave a result, not a hit
         next_res_hit = is_short || is_twin || is_twin_alt;
         next_res.trap = trap;
         next_res.addr = ea;
         next_res.asi = is_twin ? imp_asi : asi_sel;
         if (is_short && half) begin
            // shift the halfword into its lanes from the top
            sh = {3'h6 - ea[2:0], 3'h0};
            next_res.data = {48'h0, half_data} << sh;
            next_res.mask = `STS_MASK_HALF >> ea[2:0];
         end else if (is_short) begin
            // one byte into its lane
            sh = {3'h7 - ea[2:0], 3'h0};
            next_res.data = {56'h0, issue.fp_val[7:0]} << sh;
            next_res.mask = `STS_MASK_BYTE >> ea[2:0];
         end else begin
            // even word at ea, odd word at ea plus 4, one beat
            next_res.data = {w_even, w_odd};
            next_res.mask = `STS_MASK_ALL;
         end
      end
   end

   // result register, held until the memory side takes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // reset clears the result and its valid
         res_valid <= 1'b0;
         res_hit <= 1'b0;
         res <= '0;
      end else begin
         // otherwise take the next values
         res_valid <= next_res_valid;
         res_hit <= next_res_hit;
         res <= next_res;
      end
   end

   // register file next values
   always_comb begin
      // hold every register unless written or counted
      next_ctrl = ctrl;
      next_cur_asi = cur_asi;
      next_imp_asi = imp_asi;
      next_last_code = last_code;
      next_sticky = sticky;
      next_cnt = cnt;
      next_prdata = prdata;
      next_pslverr = pslverr;
      // software writes first, hardware events after so a set wins
      if (wr_acc) begin
         case (paddr)
            `STS_R_CTRL: begin
               // enables, mode and twin present
               next_ctrl = pwdata[`STS_CTRL_W-1:0];
            end
            `STS_R_ASI: begin
               // current id low, implicit id high
               next_cur_asi = pwdata[`STS_F_CUR_ASI];
               next_imp_asi = pwdata[`STS_F_IMP_ASI];
            end
            `STS_R_STAT: begin
               // write one to clear the sticky flag
               if (pwdata[`STS_B_STICKY]) begin
                  next_sticky = 1'b0;
               end
            end
            default: begin
               // read-only and unmapped writes are dropped
               next_sticky = next_sticky;
            end
         endcase
      end
      // record each result as it leaves
      if (drain) begin
         // last code kept for software
         next_last_code = res.trap;
         if (res.trap != sts_pkg::STS_TRAP_NONE) begin
            // a trap leaving sets the flag, beating a clear
            next_sticky = 1'b1;
         end else if (res_hit) begin
            // count a write handed on
            next_cnt = cnt + 32'h1;
         end
      end
      // read data and error are caught in the setup phase
      if (psel && !penable) begin
         // error clears on every new setup phase
         next_pslverr = 1'b0;
         case (paddr)
            `STS_R_CTRL: begin
               // enables and mode
               next_prdata = {27'h0, ctrl};
            end
            `STS_R_ASI: begin
               // both space ids
               next_prdata = {16'h0, imp_asi, cur_asi};
            end
            `STS_R_STAT: begin
               // sticky flag and last code
               next_prdata = {23'h0, sticky, 5'h0, last_code};
            end
            `STS_R_CNT: begin
               // writes handed on
               next_prdata = cnt;
            end
            default: begin
               // unmapped reads return zero with an error
               next_prdata = 32'h0;
               next_pslverr = 1'b1;
            end
         endcase
      end
   end

   // register file flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // reset values from the map
         ctrl <= `STS_CTRL_RST;
         cur_asi <= `STS_ASI_RST;
         imp_asi <= `STS_ASI_RST;
         last_code <= 3'h0;
         sticky <= 1'b0;
         cnt <= 32'h0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         // otherwise take the next values
         ctrl <= next_ctrl;
         cur_asi <= next_cur_asi;
         imp_asi <= next_imp_asi;
         last_code <= next_last_code;
         sticky <= next_sticky;
         cnt <= next_cnt;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

endmodule
`default_nettype wire

/* File: testbench/sts_store_unit_sva.sv */
// Purpose: port checker for the store unit
// Assumes: one pclk domain, result follows issue
// Notes: q holds the instruction behind the result
`default_nettype none
module sts_store_unit_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic pready,
   input wire logic issue_valid,
   input wire logic issue_ready,
   input wire sts_pkg::sts_issue_t issue,
   input wire logic res_valid,
   input wire logic res_ready,
   input wire sts_pkg::sts_result_t res,
   input wire logic res_hit
);
   sts_pkg::sts_issue_t q; // accepted instruction
   sts_pkg::sts_issue_t next_q;
   logic [63:0] ea; // its effective address
   logic [5:0] op3;
   logic twin;
   logic ok;
   logic [63:0] twin_exp; // both words, each swapped for little ids
   function automatic logic [31:0] sw(input logic [31:0] w);
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction
   // capture on the taking edge
   always_comb begin
      next_q = q;
      if (issue_valid && issue_ready) begin
         next_q = issue;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
   assign op3 = q.insn[24:19];
   assign ea = q.rs1_val + (q.insn[13] ? {{51{q.insn[12]}}, q.insn[12:0]} : q.rs2_val);
   assign twin = res_valid && res_hit && (op3 == 6'h07 || op3 == 6'h17);
   assign ok = res.trap == sts_pkg::STS_TRAP_NONE;
   assign twin_exp = res.asi[3] ? {sw(q.rd_even_val[31:0]), sw(q.rd_odd_val[31:0])}
      : {q.rd_even_val[31:0], q.rd_odd_val[31:0]};
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_answer_next: assert property (issue_valid && issue_ready |=> res_valid)
      else $error("no result after issue");
   a_result_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res))
      else $error("result dropped while stalled");
   a_issue_block: assert property (res_valid && !res_ready |-> !issue_ready)
      else $error("issue open while stalled");
   a_pready_high: assert property (psel |-> pready)
      else $error("apb wait state");
   a_ea_sum: assert property (res_valid && res_hit && ok |-> res.addr == ea)
      else $error("wrong address");
   a_twin_data: assert property (
      twin && ok |-> res.mask == 8'hFF && res.data == twin_exp)
      else $error("wrong twin data");
   a_twin_align: assert property (twin && ea[2:0] != 3'h0 |-> !ok)
      else $error("misaligned twin passed");
   a_twin_rd: assert property (
      twin && q.insn[25] |-> res.trap inside {sts_pkg::STS_TRAP_ILLEGAL,
      sts_pkg::STS_TRAP_UNIMPL_TWIN})
      else $error("odd rd twin passed");
   a_short_trap: assert property (res_valid && res_hit && op3 == 6'h37 |-> !ok)
      else $error("short store written");
   a_half_odd: assert property (
      res_valid && res_hit && op3 == 6'h37 && !q.insn[13] && q.insn[6] && ea[0]
      |-> res.trap inside {sts_pkg::STS_TRAP_MISALIGNED, sts_pkg::STS_TRAP_FLOAT_DISABLED_FAULT})
      else $error("odd halfword accepted");
endmodule
bind sts_store_unit sts_store_unit_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .pready(pready), .issue_valid(issue_valid), .issue_ready(issue_ready), .issue(issue),
   .res_valid(res_valid), .res_ready(res_ready), .res(res), .res_hit(res_hit));
`default_nettype wire

/* File: testbench/sts_mem_model.sv */
// Purpose: memory side taking results
// Assumes: ready may drop at any time
// Notes: stalls two cycles out of eight
`default_nettype none
module sts_mem_model (
   input wire logic pclk,
   input wire logic presetn,
   output logic res_ready
);
   logic [2:0] cnt; // stall pattern phase
   logic [2:0] next_cnt;
   // free running phase
   always_comb begin
      next_cnt = cnt + 3'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 3'h0;
      end else begin
         cnt <= next_cnt;
      end
   end
   assign res_ready = cnt[2:1] != 2'h3;
endmodule
`default_nettype wire

/* File: testbench/sts_store_unit_tb.sv */
// Purpose: self-checking bench for the store unit
// Assumes: pready answers, result one edge after issue
// Notes: table rows first, hand tests after
`default_nettype none
module sts_store_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic [31:0] insn;
      logic [7:0] rs2;
      sts_pkg::sts_trap_t trap;
      logic [11:0] addr;
      logic [7:0] asi;
      logic hit;
   } sts_row_t;
   localparam sts_pkg::sts_trap_t N = sts_pkg::STS_TRAP_NONE;
   localparam sts_pkg::sts_trap_t IL = sts_pkg::STS_TRAP_ILLEGAL;
   localparam sts_pkg::sts_trap_t FD = sts_pkg::STS_TRAP_FLOAT_DISABLED_FAULT;
   localparam sts_pkg::sts_trap_t PA = sts_pkg::STS_TRAP_PRIV_ACTION;
   localparam sts_pkg::sts_trap_t MA = sts_pkg::STS_TRAP_MISALIGNED;
   localparam sts_pkg::sts_trap_t DA = sts_pkg::STS_TRAP_DATA_ACCESS;
   localparam sts_pkg::sts_trap_t UT = sts_pkg::STS_TRAP_UNIMPL_TWIN;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, er;
   logic issue_valid, issue_ready, res_valid, res_ready, res_hit;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   sts_pkg::sts_issue_t issue;
   sts_pkg::sts_result_t res;
   int failures, checks_done, cnt_exp;
   sts_row_t rows [12];
   logic [7:0] ids [8] = '{8'hD0, 8'hD1, 8'hD8, 8'hD9, 8'hD2, 8'hD3, 8'hDA, 8'hDB};
   logic [31:0] fd [3] = '{32'h16, 32'h15, 32'h13}; // one enable or fpu missing
   always #20 pclk = ~pclk;
   sts_store_unit #(.ADDR_W(12)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .issue_valid(issue_valid),
      .issue_ready(issue_ready), .issue(issue), .res_valid(res_valid),
      .res_ready(res_ready), .res(res), .res_hit(res_hit));
   sts_mem_model mem_u (.pclk(pclk), .presetn(presetn), .res_ready(res_ready));
   function automatic logic [31:0] mk(input logic [5:0] op3, input logic [4:0] rdn,
         input logic i, input logic [12:0] lo);
      return {2'h3, rdn, op3, 5'h01, i, lo};
   endfunction
   task automatic cmp_v(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cmp_tr(input sts_pkg::sts_trap_t e, input sts_pkg::sts_trap_t g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[ERR] trap exp %0d got %0d", e, g);
      end
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one apb transfer, answer taken at the pready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // issue one instruction, take its result, compare
   task automatic run(input sts_row_t r);
      sts_pkg::sts_result_t g;
      logic h;
      @(posedge pclk);
      issue_valid <= 1'b1;
      issue <= '{r.insn, 64'h100, 64'(r.rs2), 64'hFFFFFFFF01020304, 64'hEEEEEEEE05060708, 64'h0};
      repeat (64) begin
         @(negedge pclk);
         if (issue_ready === 1'b1) break;
      end
      @(posedge pclk);
      issue_valid <= 1'b0;
      repeat (64) begin
         @(negedge pclk);
         if (res_valid === 1'b1 && res_ready === 1'b1) break;
      end
      cmp_v("res_valid", 64'h1, 64'(res_valid & res_ready));
      g = res;
      h = res_hit;
      @(posedge pclk);
      cmp_tr(r.trap, g.trap);
      cmp_v("hit", 64'(r.hit), 64'(h));
      if (r.trap == N && r.hit) begin
         cnt_exp++;
         cmp_v("addr", 64'(r.addr), g.addr);
         cmp_v("asi", 64'(r.asi), 64'(g.asi));
         cmp_v("data", r.asi[3] ? 64'h0403020108070605 : 64'h0102030405060708,
            g.data);
         cmp_v("mask", 64'hFF, 64'(g.mask));
      end
      $display("test %h done", r.insn);
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      close_out;
   end
   initial begin
      {psel, penable, pwrite, issue_valid} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      issue = '0;
      rows = '{
         '{mk(6'h07, 5'h02, 1'b1, 13'h0008), 8'h00, N, 12'h108, 8'h80, 1'b1},
         '{mk(6'h07, 5'h02, 1'b0, 13'h0000), 8'h10, N, 12'h110, 8'h80, 1'b1},
         '{mk(6'h07, 5'h02, 1'b1, 13'h1FF8), 8'h00, N, 12'h0F8, 8'h80, 1'b1},
         '{mk(6'h07, 5'h03, 1'b1, 13'h0008), 8'h00, IL, 12'h0, 8'h0, 1'b1},
         '{mk(6'h07, 5'h02, 1'b0, 13'h0020), 8'h10, IL, 12'h0, 8'h0, 1'b1},
         '{mk(6'h07, 5'h02, 1'b1, 13'h0004), 8'h00, MA, 12'h0, 8'h0, 1'b1},
         '{mk(6'h17, 5'h04, 1'b0, 13'h1000), 8'h08, N, 12'h108, 8'h80, 1'b1},
         '{mk(6'h17, 5'h04, 1'b0, 13'h1100), 8'h08, N, 12'h108, 8'h88, 1'b1},
         '{mk(6'h17, 5'h04, 1'b0, 13'h0080), 8'h08, PA, 12'h0, 8'h0, 1'b1},
         '{mk(6'h17, 5'h05, 1'b0, 13'h1000), 8'h08, IL, 12'h0, 8'h0, 1'b1},
         '{mk(6'h17, 5'h04, 1'b0, 13'h1000), 8'h04, MA, 12'h0, 8'h0, 1'b1},
         '{mk(6'h37, 5'h00, 1'b0, 13'h1000), 8'h00, N, 12'h0, 8'h0, 1'b0}};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      cmp_v("ready", 64'h1, 64'(issue_ready));
      apb(1'b0, 12'h000, 32'h0);
      cmp_v("ctrl", 64'h14, 64'(rd));
      apb(1'b0, 12'h004, 32'h0);
      cmp_v("asi", 64'h8080, 64'(rd));
      apb(1'b1, 12'h000, 32'h17);
      foreach (rows[k]) run(rows[k]);
      for (int k = 0; k < 8; k++) begin
         run('{mk(6'h37, 5'h00, 1'b0, {ids[k], 5'h00}), 8'h01, (k < 4) ? DA : MA,
            12'h0, 8'h0, 1'b1});
      end
      foreach (fd[k]) begin
         apb(1'b1, 12'h000, fd[k]);
         run('{mk(6'h37, 5'h00, 1'b0, 13'h1A40), 8'h01, FD, 12'h0, 8'h0, 1'b1});
      end
      apb(1'b1, 12'h000, 32'h07);
      run('{mk(6'h07, 5'h03, 1'b1, 13'h0008), 8'h00, UT, 12'h0, 8'h0, 1'b1});
      run('{mk(6'h17, 5'h05, 1'b0, 13'h1000), 8'h08, UT, 12'h0, 8'h0, 1'b1});
      apb(1'b1, 12'h000, 32'h1F);
      run('{mk(6'h17, 5'h04, 1'b0, 13'h0600), 8'h08, PA, 12'h0, 8'h0, 1'b1});
      run('{mk(6'h17, 5'h04, 1'b0, 13'h0FE0), 8'h08, PA, 12'h0, 8'h0, 1'b1});
      run('{mk(6'h17, 5'h04, 1'b0, 13'h0080), 8'h08, N, 12'h108, 8'h04, 1'b1});
      apb(1'b1, 12'h004, 32'h8088);
      run('{mk(6'h17, 5'h04, 1'b1, 13'h0008), 8'h00, N, 12'h108, 8'h88, 1'b1});
      run('{mk(6'h07, 5'h02, 1'b1, 13'h0008), 8'h00, N, 12'h108, 8'h80, 1'b1});
      apb(1'b0, 12'h010, 32'h0);
      cmp_v("slverr", 64'h1, 64'(er));
      apb(1'b0, 12'h00C, 32'h0);
      cmp_v("cnt", 64'(cnt_exp), 64'(rd));
      // sticky flag, its clear, then a fresh trap
      apb(1'b0, 12'h008, 32'h0);
      cmp_v("stat", 64'h100, 64'(rd));
      apb(1'b1, 12'h008, 32'h100);
      apb(1'b0, 12'h008, 32'h0);
      cmp_v("stat", 64'h0, 64'(rd));
      run('{mk(6'h07, 5'h03, 1'b1, 13'h0008), 8'h00, IL, 12'h0, 8'h0, 1'b1});
      apb(1'b0, 12'h008, 32'h0);
      cmp_v("stat", 64'h101, 64'(rd));
      // reset in mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      cmp_v("res_valid", 64'h0, 64'(res_valid));
      apb(1'b0, 12'h008, 32'h0);
      cmp_v("stat", 64'h0, 64'(rd));
      apb(1'b0, 12'h000, 32'h0);
      cmp_v("ctrl", 64'h14, 64'(rd));
      $display("reset test done");
      close_out;
   end
endmodule
`default_nettype wire
